// >>> core/drs_pkg.sv
// package of constants and types for the memory rail sequencer
package drs_pkg;
	localparam int CLK_HZ          = 40000000;
	localparam int SS_TIME_NS      = 1400000;  // soft-start ramp, 1.4 ms
	localparam int SD_TIME_NS      = 2800000;  // soft-shutdown ramp, 2.8 ms
	localparam int TERM_RAMP_NS    = 160000;   // termination limit ramp, 160 us
	localparam int UV_QUAL_NS      = 200000;   // undervoltage qualification, 200 us
	localparam int TERM_FAULT_NS   = 5000000;  // termination fault qualification, 5 ms
	localparam int NS_PER_S        = 1000000000;
	localparam int SS_CYCLES       = int'((64'(SS_TIME_NS) * CLK_HZ) / NS_PER_S);
	localparam int SD_CYCLES       = int'((64'(SD_TIME_NS) * CLK_HZ) / NS_PER_S);
	localparam int TERM_RAMP_CYCLES = int'((64'(TERM_RAMP_NS) * CLK_HZ) / NS_PER_S);
	localparam int UV_QUAL_CYCLES  = int'((64'(UV_QUAL_NS) * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam int TERM_FAULT_CYCLES = int'((64'(TERM_FAULT_NS) * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam int CNT_W           = 24;
	localparam int LIM_W           = 8;        // current limit code width
	localparam logic [LIM_W-1:0] LIM_MAX = 8'hFF;
	localparam int NEG_LIM_PCT     = 115;      // negative limit as percent of positive

	// sequencer states, gray along off -> start -> run -> stop -> off
	typedef enum logic [2:0] {
		DRS_OFF   = 3'b000,
		DRS_START = 3'b001,
		DRS_RUN   = 3'b011,
		DRS_STOP  = 3'b010,
		DRS_LATCH = 3'b110
	} drs_state_t;

	// converter operating mode
	typedef enum logic [1:0] {
		DRS_SKIP = 2'h0,
		DRS_FPWM = 2'h1,
		DRS_STBY = 2'h2
	} drs_mode_t;

	// analog comparator inputs
	typedef struct packed {
		logic bias_por;        // bias above about 2 V
		logic bias_lockout_ok; // bias above 4.1 V
		logic reference_valid;
		logic main_in_window;  // main output within 85..115 %
		logic main_over;       // overvoltage detected
		logic main_under;      // undervoltage detected
		logic thermal_fault;
		logic term_in_window;  // termination within 10 %
		logic valley_limit;    // low-side current above valley limit
		logic neg_limit;       // reverse current above negative limit
		logic zero_cross;      // inductor current crossed zero
		logic error_low;       // error comparator asks for a cycle
		logic min_off_done;
		logic on_time_done;
	} drs_sense_t;

	// gate and switch controls
	typedef struct packed {
		logic high_side_gate;
		logic low_side_gate;
		logic discharge_on;
		logic term_enable;
		logic reference_enable;
	} drs_drive_t;
endpackage : drs_pkg

// >>> core/drs_sequencer.sv
// control and supervision logic for the memory power controller
// Summary of operation
// (RQ1) forced-PWM: no zero-cross cut, low gate is complement of high gate.
// (RQ2) sleep select low forces standby over light-load select.
// (RQ3) shutdown runs the converter in forced-PWM regardless of selects.
// (RQ4) standby: termination rail off, reference buffer stays on.
// (RQ5) leaving standby enables termination and ramps its limit over 160 us.
// (RQ6) valley current above limit blocks any new switching cycle.
// (RQ7) forced-PWM also enforces negative limit near 115 percent of positive.
// (RQ8) main power-good held low in off, soft-start and soft-shutdown.
// (RQ9) after soft-start main power-good released while output within window.
// (RQ10) main fault forces both power-goods low, latched until enable toggle or power loss.
// (RQ11) overvoltage always pulls main power-good low immediately.
// (RQ12) termination power-good low in standby, shutdown and soft-start.
// (RQ13) termination power-good released only while rail within 10 percent.
// (RQ14) termination power-good low for 5 ms latches chip off via soft-shutdown.
// (RQ15) power-on clear resets latch and soft-start; discharge on if protection on.
// (RQ16) switching inhibited until bias above 4.1 V, then soft-start.
// (RQ17) bias lockout fall stops switching, low gate low, discharge if protection on; low gate stays high while overvoltage latch is set.
// (RQ18) enable rising starts soft-start ramping target over 1.4 ms.
// (RQ19) pulse-skip during startup; selects apply after soft-start.
// (RQ20) termination full limit at regulation or 160 us; reference has no ramp.
// (RQ21) soft-shutdown on enable fall, thermal, 200 us undervoltage, 5 ms termination fault.
// (RQ22) soft-shutdown ramps target to zero over 2.8 ms then low gate low.
// (RQ23) after shutdown discharge held on until enable rises, only if protection on.
// (RQ24) protected overvoltage latches low gate high and forces high gate low.
// (RQ25) pulse-skip ends low gate pulse at inductor zero crossing.
// (RQ26) all delays and ramps come from counters with constant counts.
`timescale 1ns/1ps
module drs_sequencer
	import drs_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic             power_on_request_i,
	input  wire logic             light_load_fpwm_i,
	input  wire logic             sleep_select_i,
	input  wire logic             overvoltage_protect_enable_i,
	input  wire drs_sense_t       sense_i,
	output drs_drive_t            drive_o,
	output logic                  main_output_ok_o,
	output logic                  main_output_ok_oe_o,
	output logic                  term_output_ok_o,
	output logic                  term_output_ok_oe_o,
	output logic [LIM_W-1:0]      term_limit_o,
	output logic                  neg_limit_active_o,
	output logic [CNT_W-1:0]      target_ramp_o,
	output drs_mode_t             mode_o,
	output logic                  converter_run_ok_o
);
	drs_state_t       state_reg, state_next;
	logic [CNT_W-1:0] ramp_reg, ramp_next;
	logic [CNT_W-1:0] tlim_cnt_reg, tlim_cnt_next;
	logic             fault_reg, fault_next;
	logic             ovp_latch_reg, ovp_latch_next;
	logic             req_prev_reg;
	logic             bias_prev_reg;
	logic             ss_done_reg, ss_done_next;
	logic             sd_half_reg, sd_half_next;
	logic             hs_reg, hs_next;
	logic             ls_reg, ls_next;
	logic             dis_reg, dis_next;
	logic             term_en_reg, term_en_next;
	logic             term_full_reg, term_full_next;
	logic             mpg_low_next, tpg_low_next;
	logic [LIM_W-1:0] lim_next;
	drs_mode_t        mode_next;
	logic             uv_done, tf_done, tpg_low_reg;
	logic             req_rise, req_fall, bias_fall;

	// undervoltage qualification, 200 us (RQ26)
	drs_timer #(.COUNT(UV_QUAL_CYCLES)) u_uv_timer (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.run_i  (sense_i.main_under && state_reg == DRS_RUN),
		.done_o (uv_done)
	);

	// termination power-good low qualification, 5 ms (RQ14)
	drs_timer #(.COUNT(TERM_FAULT_CYCLES)) u_tf_timer (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.run_i  (tpg_low_reg && term_en_reg && term_full_reg && state_reg == DRS_RUN),
		.done_o (tf_done)
	);

	assign req_rise  = power_on_request_i && !req_prev_reg;
	assign req_fall  = !power_on_request_i && req_prev_reg;
	assign bias_fall = !sense_i.bias_lockout_ok && bias_prev_reg;

	// sequencer state, ramps and fault latch
	always_comb begin
		state_next     = state_reg;
		ramp_next      = ramp_reg;
		fault_next     = fault_reg;
		ovp_latch_next = ovp_latch_reg;
		ss_done_next   = ss_done_reg;
		dis_next       = dis_reg;
		sd_half_next   = (state_reg == DRS_STOP) ? !sd_half_reg : 1'b0; // RQ22 half-rate phase
		if (req_rise) begin
			fault_next     = 1'b0;                            // RQ10
			ovp_latch_next = 1'b0;
			dis_next       = 1'b0;                            // RQ23
		end
		case (state_reg)
			DRS_OFF: begin
				ramp_next    = '0;
				ss_done_next = 1'b0;
				if (power_on_request_i && !fault_next && sense_i.bias_lockout_ok && sense_i.reference_valid) begin
					state_next = DRS_START;                         // RQ16 RQ18
					dis_next   = 1'b0;
				end
			end
			DRS_START: begin
				if (ramp_reg >= CNT_W'(SS_CYCLES - 1)) begin
					state_next   = DRS_RUN;                       // RQ18
					ss_done_next = 1'b1;
				end else begin
					ramp_next = ramp_reg + 1'b1;
				end
				if (!power_on_request_i || sense_i.thermal_fault)
					state_next = DRS_STOP;                          // RQ21
			end
			DRS_RUN: begin
				if (uv_done || tf_done) begin
					fault_next = 1'b1;                              // RQ10 RQ14
					state_next = DRS_STOP;                          // RQ21
				end else if (!power_on_request_i || sense_i.thermal_fault) begin
					state_next = DRS_STOP;                          // RQ21
				end
			end
			DRS_STOP: begin
				ss_done_next = 1'b0;
				if (ramp_reg == '0) begin
					ramp_next  = '0;
					state_next = fault_next ? DRS_LATCH : DRS_OFF; // RQ22
					dis_next   = overvoltage_protect_enable_i;      // RQ23
				end else begin
					ramp_next = ramp_reg - 1'b1;
				end
			end
			DRS_LATCH: begin
				ramp_next = '0;
				if (!fault_next)
					state_next = DRS_OFF;                           // RQ10
			end
			default: state_next = DRS_OFF;
		endcase
		// soft-shutdown descends at half the start slope: every other cycle holds (RQ22)
		if (state_reg == DRS_STOP && sd_half_reg && ramp_next != '0 && state_next == DRS_STOP)
			ramp_next = ramp_reg;
		if (sense_i.main_over && overvoltage_protect_enable_i && state_reg != DRS_OFF) begin
			ovp_latch_next = 1'b1;                            // RQ24
			fault_next     = 1'b1;
			dis_next       = 1'b1;
			state_next     = DRS_LATCH;
			ramp_next      = '0;
		end
		if (bias_fall) begin
			state_next = DRS_OFF;                               // RQ17
			ramp_next  = '0;
			dis_next   = overvoltage_protect_enable_i;          // RQ17
		end
		if (!sense_i.bias_por) begin
			fault_next     = 1'b0;                            // RQ15
			ovp_latch_next = 1'b0;
			state_next     = DRS_OFF;
			ramp_next      = '0;
			ss_done_next   = 1'b0;
			dis_next       = overvoltage_protect_enable_i;      // RQ15
		end
	end

	// operating mode, gates, termination and power-good
	always_comb begin
		mode_next      = DRS_SKIP;
		hs_next        = 1'b0;
		ls_next        = 1'b0;
		term_en_next   = 1'b0;
		term_full_next = term_full_reg;
		tlim_cnt_next  = tlim_cnt_reg + 1'b1;
		lim_next       = '0;
		if (state_next == DRS_STOP)
			mode_next = DRS_FPWM;                               // RQ3
		else if (ss_done_reg && !sleep_select_i)
			mode_next = DRS_STBY;                               // RQ2 RQ19
		else if (ss_done_reg && light_load_fpwm_i)
			mode_next = DRS_FPWM;                               // RQ1 RQ19
		// cycle start: on-time runs until done; valley limit withholds a start
		if (state_reg == DRS_START || state_reg == DRS_RUN || state_reg == DRS_STOP) begin
			if (hs_reg)
				hs_next = !sense_i.on_time_done;
			else
				hs_next = sense_i.error_low && sense_i.min_off_done && !sense_i.valley_limit; // RQ6
			if (mode_next == DRS_FPWM)
				ls_next = !hs_next && !sense_i.neg_limit;        // RQ1 RQ7
			else
				ls_next = !hs_next && !(sense_i.zero_cross || (!ls_reg && !hs_reg)); // RQ25
			if (state_reg == DRS_STOP && ramp_reg == '0)
				ls_next = 1'b0;                                 // RQ22
		end
		if (ovp_latch_next) begin
			hs_next = 1'b0;                                     // RQ24
			ls_next = 1'b1;                                     // RQ24
		end
		if (bias_fall || !sense_i.bias_lockout_ok) begin
			hs_next = 1'b0;                                     // RQ16 RQ17
			ls_next = ovp_latch_next;
		end
		// termination enable with linear current-limit ramp
		if (ss_done_reg && state_reg == DRS_RUN && sleep_select_i && !ovp_latch_reg)
			term_en_next = 1'b1;                                // RQ4 RQ5
		if (!term_en_reg) begin
			tlim_cnt_next  = '0;
			term_full_next = 1'b0;
		end else if (tlim_cnt_reg >= CNT_W'(TERM_RAMP_CYCLES - 1) || sense_i.term_in_window) begin
			term_full_next = 1'b1;                              // RQ20
			tlim_cnt_next  = tlim_cnt_reg;
		end
		if (term_en_reg)
			lim_next = term_full_next ? LIM_MAX :
			           LIM_W'((32'(tlim_cnt_reg) * 32'(LIM_MAX)) / TERM_RAMP_CYCLES); // RQ5
		mpg_low_next = state_reg != DRS_RUN || fault_reg || sense_i.main_over ||
		               !sense_i.main_in_window;                 // RQ8 RQ9 RQ10 RQ11
		tpg_low_next = !term_en_reg || fault_reg || state_reg != DRS_RUN ||
		               !sense_i.term_in_window;                 // RQ10 RQ12 RQ13
	end

	// register stage: every output straight from a flip-flop
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg           <= DRS_OFF;
			ramp_reg            <= '0;
			tlim_cnt_reg        <= '0;
			fault_reg           <= 1'b0;
			ovp_latch_reg       <= 1'b0;
			req_prev_reg        <= 1'b0;
			bias_prev_reg       <= 1'b0;
			ss_done_reg         <= 1'b0;
			sd_half_reg         <= 1'b0;
			hs_reg              <= 1'b0;
			ls_reg              <= 1'b0;
			dis_reg             <= 1'b0;
			term_en_reg         <= 1'b0;
			term_full_reg       <= 1'b0;
			tpg_low_reg         <= 1'b1;
			drive_o             <= '0;
			main_output_ok_o    <= 1'b0;
			main_output_ok_oe_o <= 1'b1;
			term_output_ok_o    <= 1'b0;
			term_output_ok_oe_o <= 1'b1;
			term_limit_o        <= '0;
			neg_limit_active_o  <= 1'b0;
			target_ramp_o       <= '0;
			mode_o              <= DRS_SKIP;
			converter_run_ok_o  <= 1'b0;
		end else begin
			state_reg           <= state_next;
			ramp_reg            <= ramp_next;
			tlim_cnt_reg        <= tlim_cnt_next;
			fault_reg           <= fault_next;
			ovp_latch_reg       <= ovp_latch_next;
			req_prev_reg        <= power_on_request_i;
			bias_prev_reg       <= sense_i.bias_lockout_ok;
			ss_done_reg         <= ss_done_next;
			sd_half_reg         <= sd_half_next;
			hs_reg              <= hs_next;
			ls_reg              <= ls_next;
			dis_reg             <= dis_next;
			term_en_reg         <= term_en_next;
			term_full_reg       <= term_full_next;
			tpg_low_reg         <= tpg_low_next;
			drive_o             <= '{high_side_gate: hs_next, low_side_gate: ls_next, discharge_on: dis_next,
			                         term_enable: term_en_next, reference_enable: 1'b1}; // RQ4 RQ20
			main_output_ok_o    <= 1'b0;                        // open drain: only ever drives low
			main_output_ok_oe_o <= mpg_low_next;                // RQ8 RQ9 RQ11
			term_output_ok_o    <= 1'b0;
			term_output_ok_oe_o <= tpg_low_next;                // RQ12 RQ13
			term_limit_o        <= lim_next;
			neg_limit_active_o  <= mode_next == DRS_FPWM;       // RQ7
			target_ramp_o       <= ramp_next;
			mode_o              <= mode_next;
			converter_run_ok_o  <= state_next == DRS_RUN;
		end
	end
endmodule : drs_sequencer

// >>> core/drs_timer.sv
// qualifying counter: raises done once the condition has held for the full count
`timescale 1ns/1ps
module drs_timer
	import drs_pkg::*;
#(
	parameter int COUNT = 8
) (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic run_i,
	output logic      done_o
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             done_next;

	// count while run held, clear otherwise, saturate at the limit
	always_comb begin
		cnt_next  = '0;
		done_next = 1'b0;
		if (run_i) begin
			if (cnt_reg >= CNT_W'(COUNT - 1)) begin
				cnt_next  = cnt_reg;
				done_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_reg <= '0;
			done_o  <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			done_o  <= done_next;
		end
	end
endmodule : drs_timer

// >>> verif/drs_far_side.sv
// stand-in for the comparators that answer the gate drivers
`timescale 1ns/1ps
module drs_far_side
	import drs_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       slow_i,
	input  wire drs_drive_t drive_i,
	input  wire drs_sense_t lvl_i,
	output drs_sense_t      sense_o
);
	logic [2:0] hs_cnt;
	logic [2:0] off_cnt;
	logic [2:0] ls_cnt;

	// saturating time spent in each gate state
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hs_cnt  <= 3'h0;
			off_cnt <= 3'h0;
			ls_cnt  <= 3'h0;
		end else begin
			hs_cnt  <= drive_i.high_side_gate ? hs_cnt + 3'(hs_cnt != 3'h7) : 3'h0;
			off_cnt <= drive_i.high_side_gate ? 3'h0 : off_cnt + 3'(off_cnt != 3'h7);
			ls_cnt  <= drive_i.low_side_gate ? ls_cnt + 3'(ls_cnt != 3'h7) : 3'h0;
		end
	end

	// static levels from the bench, one-shots and zero crossing from the counts
	always_comb begin
		sense_o              = lvl_i;
		sense_o.on_time_done = hs_cnt >= (slow_i ? 3'h6 : 3'h2);
		sense_o.min_off_done = off_cnt >= 3'h2;
		sense_o.zero_cross   = ls_cnt >= 3'h3;
	end
endmodule : drs_far_side

// >>> verif/drs_sequencer_chk.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module drs_sequencer_chk
	import drs_pkg::*;
(
	input wire logic             clk_i,
	input wire logic             nrst_i,
	input wire logic             sleep_select_i,
	input wire logic             overvoltage_protect_enable_i,
	input wire drs_sense_t       sense_i,
	input wire drs_drive_t       drive_o,
	input wire logic             main_output_ok_oe_o,
	input wire logic             term_output_ok_oe_o,
	input wire logic [LIM_W-1:0] term_limit_o,
	input wire logic [CNT_W-1:0] target_ramp_o,
	input wire drs_mode_t        mode_o,
	input wire logic             converter_run_ok_o
);
	logic [12:0] ramp_cnt;

	// cycles the termination limit has spent below full while enabled
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ramp_cnt <= 13'h0000;
		end else begin
			ramp_cnt <= (drive_o.term_enable && term_limit_o != LIM_MAX) ? ramp_cnt + 13'h0001 : 13'h0000;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	property p_fpwm_comp;
		converter_run_ok_o && mode_o == DRS_FPWM && $past(mode_o) == DRS_FPWM
		|-> drive_o.low_side_gate == !drive_o.high_side_gate;
	endproperty
	a_fpwm_comp: assert property (p_fpwm_comp) else $error("gates not complementary");
	property p_stby;
		converter_run_ok_o && $past(converter_run_ok_o) && !$past(sleep_select_i) |-> mode_o == DRS_STBY;
	endproperty
	a_stby: assert property (p_stby) else $error("sleep select ignored");
	property p_stop_fpwm;
		$fell(converter_run_ok_o) && !$past(sense_i.main_over) && $past(sense_i.bias_lockout_ok)
		|-> mode_o == DRS_FPWM;
	endproperty
	a_stop_fpwm: assert property (p_stop_fpwm) else $error("shutdown not in forced mode");
	property p_stby_term;
		mode_o == DRS_STBY && $past(mode_o) == DRS_STBY |-> !drive_o.term_enable && drive_o.reference_enable;
	endproperty
	a_stby_term: assert property (p_stby_term) else $error("standby rail state wrong");
	property p_ramp;
		ramp_cnt <= 13'(TERM_RAMP_CYCLES + 4);
	endproperty
	a_ramp: assert property (p_ramp) else $error("limit ramp too long");
	property p_main_low;
		!converter_run_ok_o && !$past(converter_run_ok_o) |-> main_output_ok_oe_o;
	endproperty
	a_main_low: assert property (p_main_low) else $error("main good released early");
	property p_ov_pg;
		sense_i.main_over |=> main_output_ok_oe_o;
	endproperty
	a_ov_pg: assert property (p_ov_pg) else $error("overvoltage left main good high");
	property p_term_win;
		!sense_i.term_in_window |=> term_output_ok_oe_o;
	endproperty
	a_term_win: assert property (p_term_win) else $error("term good high outside window");
	property p_ov_latch;
		sense_i.main_over && overvoltage_protect_enable_i && target_ramp_o != 24'h000000
		|=> drive_o.low_side_gate && !drive_o.high_side_gate;
	endproperty
	a_ov_latch: assert property (p_ov_latch) else $error("overvoltage gates wrong");
endmodule : drs_sequencer_chk

bind drs_sequencer drs_sequencer_chk u_chk (.*);

// >>> verif/drs_sequencer_tb_top.sv
// self-checking bench for the memory rail sequencer
`timescale 1ns/1ps
module drs_sequencer_tb_top
	import drs_pkg::*;
;
	logic             clk_i = 1'b0;
	logic             nrst_i = 1'b0;
	logic             power_on_request_i = 1'b0;
	logic             light_load_fpwm_i = 1'b1;
	logic             sleep_select_i = 1'b0;
	logic             overvoltage_protect_enable_i = 1'b0;
	logic             slow = 1'b0;
	drs_sense_t       lvl;
	drs_sense_t       sense_i;
	drs_drive_t       drive_o;
	logic             main_output_ok_o;
	logic             main_output_ok_oe_o;
	logic             term_output_ok_o;
	logic             term_output_ok_oe_o;
	logic [LIM_W-1:0] term_limit_o;
	logic             neg_limit_active_o;
	logic [CNT_W-1:0] target_ramp_o;
	drs_mode_t        mode_o;
	logic             converter_run_ok_o;
	int               num_errors = 0;
	int               n_checks = 0;

	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;

	drs_sequencer dut (.*);
	drs_far_side u_far (.clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow), .drive_i(drive_o), .lvl_i(lvl), .sense_o(sense_i));

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask : cyc

	task automatic end_of_test;
		if (num_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	// startup with standby strapped, then the selects take effect
	task automatic t_start;
		int n;
		power_on_request_i = 1'b1;
		cyc(1000);
		chk(mode_o, DRS_SKIP);
		chk({main_output_ok_oe_o, term_output_ok_oe_o}, 2'b11);
		n = 1000;
		while (!converter_run_ok_o && n < SS_CYCLES + 100) begin
			cyc(1);
			n++;
		end
		chk(n >= SS_CYCLES - 2 && n <= SS_CYCLES + 3, 1'b1);
		cyc(2);
		chk(mode_o, DRS_STBY);
		chk({drive_o.term_enable, drive_o.reference_enable, term_output_ok_oe_o}, 3'b011);
	endtask : t_start

	// leave standby: limit ramp, windows, gate complement
	task automatic t_term;
		sleep_select_i = 1'b1;
		cyc(3);
		chk({mode_o, neg_limit_active_o, drive_o.term_enable}, {DRS_FPWM, 2'b11});
		cyc(TERM_RAMP_CYCLES / 2);
		chk(term_limit_o > 8'h40 && term_limit_o < 8'hC0, 1'b1);
		cyc(TERM_RAMP_CYCLES / 2 + 4);
		chk({term_limit_o, term_output_ok_oe_o}, {LIM_MAX, 1'b1});
		lvl.term_in_window = 1'b1;
		lvl.main_in_window = 1'b0;
		cyc(2);
		chk({term_output_ok_oe_o, main_output_ok_oe_o}, 2'b01);
		lvl.main_in_window = 1'b1;
		cyc(2);
		chk(main_output_ok_oe_o, 1'b0);
		for (int i = 0; i < 20; i++) begin
			cyc(1);
			chk(drive_o.low_side_gate, !drive_o.high_side_gate);
		end
		sleep_select_i = 1'b0;
		cyc(3);
		chk(term_output_ok_oe_o, 1'b1);
		sleep_select_i = 1'b1;
		cyc(6);
		chk(term_limit_o, LIM_MAX);
	endtask : t_term

	// pulse-skip with the valley limit held, then released
	task automatic t_skip;
		logic hs;
		int   run;
		int   mx;
		hs = 1'b0;
		run = 0;
		mx = 0;
		slow = 1'b1;
		light_load_fpwm_i = 1'b0;
		lvl.valley_limit = 1'b1;
		cyc(10);
		chk(neg_limit_active_o, 1'b0);
		for (int i = 0; i < 30; i++) begin
			cyc(1);
			hs = hs | drive_o.high_side_gate;
		end
		chk(hs, 1'b0);
		lvl.valley_limit = 1'b0;
		for (int i = 0; i < 30; i++) begin
			cyc(1);
			hs = hs | drive_o.high_side_gate;
			run = drive_o.low_side_gate ? run + 1 : 0;
			mx = (run > mx) ? run : mx;
		end
		chk({hs, mx <= 6}, 2'b11);
	endtask : t_skip

	// unprotected overvoltage only drops main good
	task automatic t_ov_free;
		lvl.main_over = 1'b1;
		cyc(2);
		chk({main_output_ok_oe_o, converter_run_ok_o}, 2'b11);
		lvl.main_over = 1'b0;
		cyc(2);
		chk(main_output_ok_oe_o, 1'b0);
	endtask : t_ov_free

	// qualified undervoltage starts soft-shutdown, then a reset during the soft-shutdown
	task automatic t_uv;
		int n;
		logic [CNT_W-1:0] t0;
		lvl.main_under = 1'b1;
		cyc(UV_QUAL_CYCLES - 20);
		chk(converter_run_ok_o, 1'b1);
		n = 0;
		while (converter_run_ok_o && n < 60) begin
			cyc(1);
			n++;
		end
		cyc(2);
		chk({converter_run_ok_o, mode_o, main_output_ok_oe_o, term_output_ok_oe_o}, {1'b0, DRS_FPWM, 2'b11});
		t0 = target_ramp_o;
		cyc(100);
		chk(target_ramp_o < t0, 1'b1);
		lvl.main_under = 1'b0;
		nrst_i = 1'b0;
		cyc(3);
		power_on_request_i = 1'b0;
		nrst_i = 1'b1;
		cyc(2);
	endtask : t_uv

	// protected overvoltage latch, release by enable toggle, bias loss
	task automatic t_ov_latch;
		overvoltage_protect_enable_i = 1'b1;
		power_on_request_i = 1'b1;
		cyc(200);
		lvl.main_over = 1'b1;
		cyc(2);
		chk({drive_o.low_side_gate, drive_o.high_side_gate, drive_o.discharge_on}, 3'b101);
		chk({main_output_ok_oe_o, term_output_ok_oe_o}, 2'b11);
		lvl.main_over = 1'b0;
		cyc(20);
		chk(drive_o.low_side_gate, 1'b1);
		power_on_request_i = 1'b0;
		cyc(3);
		chk(drive_o.discharge_on, 1'b1);
		power_on_request_i = 1'b1;
		cyc(5);
		chk({drive_o.discharge_on, target_ramp_o != 24'h000000}, 2'b01);
		lvl.bias_lockout_ok = 1'b0;
		cyc(3);
		chk({drive_o.high_side_gate, drive_o.low_side_gate, drive_o.discharge_on}, 3'b001);
	endtask : t_ov_latch

	// main sequence
	initial begin
		lvl = '0;
		lvl.bias_por = 1'b1;
		lvl.bias_lockout_ok = 1'b1;
		lvl.reference_valid = 1'b1;
		lvl.main_in_window = 1'b1;
		lvl.error_low = 1'b1;
		cyc(20);
		nrst_i = 1'b1;
		cyc(1);
		chk({main_output_ok_oe_o, term_output_ok_oe_o, mode_o, converter_run_ok_o}, 5'b11000);
		t_start();
		t_term();
		t_skip();
		t_ov_free();
		t_uv();
		t_ov_latch();
		end_of_test();
	end

	// watchdog sized above the roughly 71k cycles the tests need
	initial begin
		#(90000 * 25);
		num_errors++;
		end_of_test();
	end
endmodule : drs_sequencer_tb_top
